// ===== rtl/atm_pkg.sv
// constants, types and timing counts of the absolute-position transfer engine
package atm_pkg;
   localparam int unsigned ATM_CLK_HZ         = 10_000_000;
   localparam int unsigned ATM_MODE_LIMIT_S   = 5;
   localparam int unsigned ATM_REQ_LIMIT_S    = 1;
   localparam int unsigned ATM_MODE_LIMIT_CYC = ATM_MODE_LIMIT_S * ATM_CLK_HZ;
   localparam int unsigned ATM_REQ_LIMIT_CYC  = ATM_REQ_LIMIT_S * ATM_CLK_HZ;
   localparam int          ATM_TMR_W          = 26;

   localparam logic [7:0]  ATM_OFF_CTRL   = 8'h00;
   localparam logic [7:0]  ATM_OFF_POS    = 8'h04;
   localparam logic [7:0]  ATM_OFF_STATUS = 8'h08;
   localparam logic [7:0]  ATM_OFF_MASK   = 8'h0C;
   localparam logic [7:0]  ATM_OFF_STATE  = 8'h10;

   localparam int          ATM_CTRL_EN_BIT = 0;
   localparam int          ATM_EV_WARN_BIT = 0;
   localparam int          ATM_EV_DONE_BIT = 1;
   localparam int          ATM_EV_W        = 2;

   localparam logic [4:0]  ATM_POS_CHUNKS = 5'h10;
   localparam logic [4:0]  ATM_CHUNKS     = 5'h13;

   localparam logic [1:0]  ATM_CAUSE_NONE = 2'h0;
   localparam logic [1:0]  ATM_CAUSE_ON   = 2'h1;
   localparam logic [1:0]  ATM_CAUSE_MODE = 2'h2;
   localparam logic [1:0]  ATM_CAUSE_OFF  = 2'h3;

   localparam logic        ATM_CTRL_RST   = 1'h0;
   localparam logic [31:0] ATM_POS_RST    = 32'h0000_0000;
   localparam logic [1:0]  ATM_MASK_RST   = 2'h0;

   typedef enum logic [2:0] {
      ATM_IDLE,
      ATM_WAIT_REQ,
      ATM_WAIT_REL,
      ATM_DONE,
      ATM_WARN
   } atm_phase_t;
endpackage : atm_pkg

// ===== rtl/atm_timer.sv
// phase timer: counts enabled cycles while run is high, flags when the limit is reached
`timescale 1ns/1ns
module atm_timer
   import atm_pkg::*;
(
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 ce,
   input  wire logic                 run,
   input  wire logic [ATM_TMR_W-1:0] limit,
   output      logic                 expired
);
   typedef struct packed {
      logic [ATM_TMR_W-1:0] cnt;
      logic                 hit;
   } atm_tmr_t;

   atm_tmr_t st_r;
   atm_tmr_t st_nxt;

   // dropping run restarts the count; the on and off timers time each phase from its own start, the mode timer the whole frame
   always_comb begin
      st_nxt = st_r;
      if (!run) begin
         st_nxt.cnt = '0;
         st_nxt.hit = 1'b0;
      end else if (st_r.cnt != limit) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
         st_nxt.hit = (st_nxt.cnt == limit);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign expired = st_r.hit;
endmodule : atm_timer

// ===== rtl/atm_chunk_sel.sv
// picks the 2-bit chunk for a transfer step: 16 position chunks then a 6-bit sum
`timescale 1ns/1ns
module atm_chunk_sel
   import atm_pkg::*;
(
   input  wire logic [31:0] pos,
   input  wire logic [4:0]  idx,
   output      logic [1:0]  chunk
);
   logic [5:0] psum [0:16];

   assign psum[0] = 6'h00;
   for (genvar g = 0; g < 16; g++) begin : g_sum
      assign psum[g+1] = psum[g] + {4'h0, pos[2*g +: 2]};
   end

   always_comb begin
      case (idx)
         5'h10:   chunk = psum[16][1:0];
         5'h11:   chunk = psum[16][3:2];
         5'h12:   chunk = psum[16][5:4];
         default: chunk = pos[{idx[3:0], 1'b0} +: 2];
      endcase
   end
endmodule : atm_chunk_sel

// ===== rtl/atm_transfer.sv
// amplifier-side absolute position transfer engine with ahb-lite registers
`timescale 1ns/1ns
module atm_transfer
   import atm_pkg::*;
#(
   parameter int unsigned MODE_LIMIT_CYC = ATM_MODE_LIMIT_CYC,
   parameter int unsigned REQ_LIMIT_CYC  = ATM_REQ_LIMIT_CYC
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   input  wire logic        transfer_mode_in,
   input  wire logic        data_request_in,
   output      logic        transmit_data_ready,
   output      logic        positioning_done_line,
   output      logic        zero_speed_line,
   output      logic        transfer_timeout_warning,
   output      logic        irq
);
   typedef struct packed {
      atm_phase_t           phase;
      logic [4:0]           idx;
      logic [31:0]          pos_lat;
      logic                 mode_q;
      logic [1:0]           cause;
      logic                 ctrl_en;
      logic [31:0]          pos;
      logic [ATM_EV_W-1:0]  status;
      logic [ATM_EV_W-1:0]  mask;
      logic                 wr_pend;
      logic [7:0]           wr_addr;
      logic [31:0]          rdata;
      logic                 rdy_o;
      logic                 ready_o;
      logic [1:0]           bits_o;
      logic                 warn_o;
      logic                 irq_o;
   } atm_regs_t;

   localparam logic [ATM_TMR_W-1:0] MODE_LIM = ATM_TMR_W'(MODE_LIMIT_CYC);
   localparam logic [ATM_TMR_W-1:0] REQ_LIM  = ATM_TMR_W'(REQ_LIMIT_CYC);

   atm_regs_t st_r;
   atm_regs_t st_nxt;
   logic      on_exp;
   logic      off_exp;
   logic      mode_exp;
   logic [1:0] chunk;
   logic      active;

   assign active = (st_r.phase == ATM_WAIT_REQ) || (st_r.phase == ATM_WAIT_REL);

   atm_timer u_on_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .run     (st_r.phase == ATM_WAIT_REL),
      .limit   (REQ_LIM),
      .expired (on_exp)
   );

   atm_timer u_off_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .run     (st_r.phase == ATM_WAIT_REQ),
      .limit   (REQ_LIM),
      .expired (off_exp)
   );

   atm_timer u_mode_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .run     (active),
      .limit   (MODE_LIM),
      .expired (mode_exp)
   );

   atm_chunk_sel u_chunk (
      .pos   (st_r.pos_lat),
      .idx   (st_r.idx),
      .chunk (chunk)
   );

   logic                 addr_take;
   logic [ATM_EV_W-1:0]  ev;
   logic [ATM_EV_W-1:0]  rd_clr;

   assign addr_take = hsel && htrans[1] && hready;

   always_comb begin
      st_nxt     = st_r;
      ev         = '0;
      rd_clr     = '0;
      st_nxt.mode_q = transfer_mode_in;

      case (st_r.phase)
         ATM_IDLE: begin
            if (st_r.ctrl_en && transfer_mode_in && !st_r.mode_q) begin
               st_nxt.phase   = ATM_WAIT_REQ;
               st_nxt.idx     = 5'h00;
               st_nxt.pos_lat = st_r.pos;
               st_nxt.cause   = ATM_CAUSE_NONE;
               st_nxt.ready_o = 1'b1;
            end
         end
         ATM_WAIT_REQ: begin
            if (mode_exp) begin
               st_nxt.phase = ATM_WARN;
               st_nxt.cause = ATM_CAUSE_MODE;
            end else if (off_exp) begin
               st_nxt.phase = ATM_WARN;
               st_nxt.cause = ATM_CAUSE_OFF;
            end else if (!transfer_mode_in) begin
               st_nxt.phase = ATM_IDLE;
            end else if (data_request_in) begin
               st_nxt.bits_o  = chunk;
               st_nxt.ready_o = 1'b0;
               st_nxt.phase   = ATM_WAIT_REL;
            end
         end
         ATM_WAIT_REL: begin
            if (mode_exp) begin
               st_nxt.phase = ATM_WARN;
               st_nxt.cause = ATM_CAUSE_MODE;
            end else if (on_exp) begin
               st_nxt.phase = ATM_WARN;
               st_nxt.cause = ATM_CAUSE_ON;
            end else if (!data_request_in) begin
               st_nxt.ready_o = 1'b1;
               if (st_r.idx == ATM_CHUNKS - 5'h01) begin
                  st_nxt.phase = ATM_DONE;
                  ev[ATM_EV_DONE_BIT] = 1'b1;
               end else begin
                  st_nxt.idx   = st_r.idx + 5'h01;
                  st_nxt.phase = ATM_WAIT_REQ;
               end
            end
         end
         ATM_DONE: begin
            if (!transfer_mode_in) begin
               st_nxt.phase = ATM_IDLE;
            end
         end
         ATM_WARN: begin
            // warning holds until the controller drops both lines
            st_nxt.ready_o = 1'b1;
            if (!transfer_mode_in && !data_request_in) begin
               st_nxt.phase = ATM_IDLE;
            end
         end
         default: begin
            st_nxt.phase = ATM_IDLE;
         end
      endcase

      if (st_nxt.phase == ATM_WARN && st_r.phase != ATM_WARN) begin
         ev[ATM_EV_WARN_BIT] = 1'b1;
      end
      st_nxt.warn_o = (st_nxt.phase == ATM_WARN);
      if (st_nxt.phase == ATM_IDLE) begin
         st_nxt.ready_o = 1'b1;
      end

      // bus: address phase is captured, data phase answers with zero wait states
      st_nxt.wr_pend = 1'b0;
      if (st_r.wr_pend) begin
         case (st_r.wr_addr)
            ATM_OFF_CTRL: st_nxt.ctrl_en = hwdata[ATM_CTRL_EN_BIT];
            ATM_OFF_POS:  st_nxt.pos     = hwdata;
            ATM_OFF_MASK: st_nxt.mask    = hwdata[ATM_EV_W-1:0];
            default: ;
         endcase
      end
      if (addr_take) begin
         st_nxt.wr_pend = hwrite;
         st_nxt.wr_addr = haddr[7:0];
         st_nxt.rdata   = 32'h0000_0000;
         if (!hwrite) begin
            case (haddr[7:0])
               ATM_OFF_CTRL:   st_nxt.rdata = {31'h0, st_r.ctrl_en};
               ATM_OFF_POS:    st_nxt.rdata = st_r.pos;
               ATM_OFF_STATUS: begin
                  st_nxt.rdata = {30'h0, st_r.status};
                  rd_clr       = st_r.status;
               end
               ATM_OFF_MASK:   st_nxt.rdata = {30'h0, st_r.mask};
               ATM_OFF_STATE:  st_nxt.rdata = {21'h0, st_r.cause, st_r.idx, st_r.phase, st_r.warn_o};
               default:        st_nxt.rdata = 32'h0000_0000;
            endcase
         end
      end
      // a new event in the clearing cycle survives: clear only what was read
      st_nxt.status = (st_r.status & ~rd_clr) | ev;
      st_nxt.irq_o  = |(st_nxt.status & st_nxt.mask);
      st_nxt.rdy_o  = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r         <= '0;
         st_r.phase   <= ATM_IDLE;
         st_r.ctrl_en <= ATM_CTRL_RST;
         st_r.pos     <= ATM_POS_RST;
         st_r.mask    <= ATM_MASK_RST;
         st_r.rdy_o   <= 1'b1;
         st_r.ready_o <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout                = st_r.rdy_o;
   assign hresp                    = 1'b0;
   assign hrdata                   = st_r.rdata;
   assign transmit_data_ready      = st_r.ready_o;
   assign positioning_done_line    = st_r.bits_o[0];
   assign zero_speed_line          = st_r.bits_o[1];
   assign transfer_timeout_warning = st_r.warn_o;
   assign irq                      = st_r.irq_o;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_req_on_warn: assert property (ce && st_r.phase == ATM_WAIT_REL && on_exp && !mode_exp
      |=> transfer_timeout_warning && st_r.cause == ATM_CAUSE_ON)
      else $error("request on-time expiry gave no warning");
   a_mode_warn: assert property (ce && active && mode_exp
      |=> transfer_timeout_warning && st_r.cause == ATM_CAUSE_MODE)
      else $error("transfer-mode expiry gave no warning");
   a_req_off_warn: assert property (ce && st_r.phase == ATM_WAIT_REQ && off_exp && !mode_exp
      |=> transfer_timeout_warning ##1 (transfer_timeout_warning || !transfer_mode_in))
      else $error("request off-time expiry gave no warning");
   a_bits_on_lines: assert property (ce && st_r.phase == ATM_WAIT_REQ && data_request_in
      && transfer_mode_in && !off_exp && !mode_exp
      |=> !transmit_data_ready && {zero_speed_line, positioning_done_line} == $past(chunk))
      else $error("data bits not placed on output lines");
   a_irq_level: assert property (irq == |(st_r.status & st_r.mask))
      else $error("interrupt level disagrees with status and mask");

   // what the controller and the bus master may rely on; a frozen enable must not lose a step
   a_ce_freeze: assert property (!ce |=> $stable(st_r))
      else $error("state moved while clock enable was low");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus inserted a wait state or an error");
   a_idle_quiet: assert property (st_r.phase == ATM_IDLE |-> transmit_data_ready && !transfer_timeout_warning)
      else $error("idle phase shows ready low or a warning");
   a_xfer_start: assert property (ce && st_r.phase == ATM_IDLE && st_r.ctrl_en && transfer_mode_in
      && !st_r.mode_q |=> st_r.phase == ATM_WAIT_REQ && st_r.idx == 5'h00 && st_r.pos_lat == $past(st_r.pos))
      else $error("rising transfer mode did not start a frame");
   a_ready_back: assert property (ce && st_r.phase == ATM_WAIT_REL && !data_request_in && !on_exp
      && !mode_exp |=> transmit_data_ready)
      else $error("ready stayed low after the request was released");
   a_lines_hold: assert property (ce && st_r.phase != ATM_WAIT_REQ
      |=> $stable({zero_speed_line, positioning_done_line}))
      else $error("data lines moved outside a request step");
   a_idx_range: assert property (st_r.idx < ATM_CHUNKS)
      else $error("chunk index ran past the frame");
   a_done_event: assert property (ce && st_r.phase == ATM_WAIT_REL && st_r.idx == ATM_CHUNKS - 5'h01
      && !data_request_in && !on_exp && !mode_exp |=> st_r.status[ATM_EV_DONE_BIT])
      else $error("finished frame did not set the done event");
   a_warn_holds: assert property (ce && transfer_timeout_warning
      && (transfer_mode_in || data_request_in) |=> transfer_timeout_warning)
      else $error("warning dropped while a controller line was still high");
   a_warn_ends: assert property (ce && transfer_timeout_warning
      && !transfer_mode_in && !data_request_in |=> !transfer_timeout_warning && transmit_data_ready)
      else $error("warning outlived the release of both lines");
   a_read_clears: assert property (ce && addr_take && !hwrite && haddr[7:0] == ATM_OFF_STATUS
      |=> (st_r.status & $past(st_r.status) & ~$past(ev)) == '0)
      else $error("status bits survived their own read");
   a_cause_fresh: assert property (st_r.phase == ATM_WAIT_REQ && st_r.idx == 5'h00
      |-> st_r.cause == ATM_CAUSE_NONE)
      else $error("a new frame kept the cause of an old warning");
   a_abort_idle: assert property (ce && st_r.phase == ATM_WAIT_REQ && !transfer_mode_in
      && !off_exp && !mode_exp |=> st_r.phase == ATM_IDLE)
      else $error("dropped transfer mode did not abort the frame");
   a_off_restart: assert property (ce && st_r.phase != ATM_WAIT_REQ |=> !off_exp)
      else $error("off-time timer kept its count across a step");
   a_on_restart: assert property (ce && st_r.phase != ATM_WAIT_REL |=> !on_exp)
      else $error("on-time timer kept its count across a step");

   c_done: cover property (st_r.phase == ATM_WAIT_REL ##1 st_r.phase == ATM_DONE);
   c_warn: cover property ($rose(transfer_timeout_warning));
   c_status_rd: cover property (addr_take && !hwrite && haddr[7:0] == ATM_OFF_STATUS && |st_r.status);
   c_ce_pause: cover property (!ce ##1 ce);
   c_mode_cause: cover property (st_r.phase == ATM_WARN && st_r.cause == ATM_CAUSE_MODE);
endmodule : atm_transfer

// ===== test/atm_ctrl_model.sv
// controller-side model: drives transfer mode and data request, gathers chunks
`timescale 1ns/1ns
module atm_ctrl_model (
   input  wire logic hclk,
   input  wire logic transmit_data_ready,
   input  wire logic positioning_done_line,
   input  wire logic zero_speed_line,
   input  wire logic transfer_timeout_warning,
   output logic      transfer_mode_out,
   output logic      data_request_out
);
   // latched communication error of the controller; no motion is commanded here, so the motor
   // stays stopped and torque limiting stays off for the whole transfer
   logic comm_error_flag;
   initial begin
      transfer_mode_out = 1'b0;
      data_request_out  = 1'b0;
      comm_error_flag   = 1'b0;
   end
   // bounded wait for ready at a level; a warning ends it early
   task automatic wait_rdy(input logic lvl, output logic ok);
      int n;
      n = 0;
      while (transmit_data_ready !== lvl && transfer_timeout_warning !== 1'b1 && n < 2000) begin
         @(posedge hclk);
         n++;
      end
      ok = (transmit_data_ready === lvl || transfer_timeout_warning === 1'b1);
   endtask : wait_rdy
   // hold: 0 normal, 1 request left on, 2 request never raised
   task automatic xfer(input int gap, input int hold, output logic [31:0] pos, output logic [5:0] sum,
                       output logic warned, output logic ok);
      logic [1:0] c;
      int         i;
      pos = '0;
      sum = '0;
      warned = 1'b0;
      ok = 1'b1;
      transfer_mode_out <= 1'b1;
      for (i = 0; i < 19 && !warned && ok; i++) begin
         repeat (gap + 1) @(posedge hclk);
         if (hold != 2) data_request_out <= 1'b1;
         @(posedge hclk);
         wait_rdy(1'b0, ok);
         // a warning means the amplifier gave up; treated as a communication error
         if (transfer_timeout_warning === 1'b1) warned = 1'b1;
         else begin
            c = {zero_speed_line, positioning_done_line};
            if (i < 16) pos[2*i +: 2] = c;
            else sum[2*(i-16) +: 2] = c;
            if (hold != 1) data_request_out <= 1'b0;
            @(posedge hclk);
            wait_rdy(1'b1, ok);
            warned = (transfer_timeout_warning === 1'b1);
         end
      end
      if (warned) comm_error_flag = 1'b1;
      // on a warning the lines stay put so the bench can look at the state first
      if (!warned) begin
         transfer_mode_out <= 1'b0;
         @(posedge hclk);
      end
   endtask : xfer
   task automatic release_lines();
      comm_error_flag = 1'b0; // servo-on button off once the cause is gone
      transfer_mode_out <= 1'b0;
      data_request_out  <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask : release_lines
endmodule : atm_ctrl_model

// ===== test/tb.sv
// self-checking bench: register map, position frames and timeout warnings
`timescale 1ns/1ns
module tb;
   import atm_pkg::*;
   localparam int unsigned MODE_CYC = 200;
   localparam int unsigned REQ_CYC  = 40;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        mode, req, rdy, pd, zs, warn, warned, ok, ce;
   logic [1:0]  htrans;
   logic [5:0]  sum;
   logic [31:0] haddr, hwdata, hrdata, rd, pos, got;
   logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [1:0]  cause [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   int          seed, bad_count, tests_run, k, miss;
   atm_transfer #(.MODE_LIMIT_CYC(MODE_CYC), .REQ_LIMIT_CYC(REQ_CYC)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .transfer_mode_in(mode), .data_request_in(req), .transmit_data_ready(rdy), .positioning_done_line(pd),
      .zero_speed_line(zs), .transfer_timeout_warning(warn), .irq(irq));
   atm_ctrl_model u_ctrl (
      .hclk(hclk), .transmit_data_ready(rdy), .positioning_done_line(pd), .zero_speed_line(zs),
      .transfer_timeout_warning(warn), .transfer_mode_out(mode), .data_request_out(req));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one slave, so its hreadyout is the bus hready
   task automatic wait_hready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         finish_test();
      end
   endtask : wait_hready
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_hready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_hready();
      r = hrdata;
   endtask : ahb
   function automatic logic [5:0] csum(input logic [31:0] p);
      logic [5:0] s;
      s = 6'h00;
      for (int i = 0; i < 16; i++) s += {4'h0, p[2*i +: 2]};
      return s;
   endfunction : csum
   initial begin
      seed = 28613;
      miss = 0;
      ce = 1'b1;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({29'h0, rdy, warn, irq}, 32'h4);
      // reset values, the unmapped place and a write to the read-only state
      ahb(8'h10, 1'b1, 32'hFFFF_FFFF, rd);
      ahb(8'h14, 1'b1, 32'hFFFF_FFFF, rd);
      foreach (offs[i]) begin
         ahb(offs[i], 1'b0, 32'h0, rd);
         check(rd, 32'h0);
      end
      ahb(8'h0C, 1'b1, 32'h3, rd);
      ahb(8'h0C, 1'b0, 32'h0, rd);
      check(rd, 32'h3);
      ahb(8'h00, 1'b1, 32'h1, rd);
      $display("register test done");
      // whole frames: all-zero and all-one corners, then random positions
      for (k = 0; k < 6; k++) begin
         pos = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFF_FFFF : $random(seed);
         ahb(8'h04, 1'b1, pos, rd);
         u_ctrl.xfer($random(seed) & 1, 0, got, sum, warned, ok);
         check(got, pos);
         check({26'h0, sum}, {26'h0, csum(pos)});
         miss = (sum === csum(got)) ? 0 : miss + 1;
         check({31'h0, miss >= 4}, 32'h0);
         check({30'h0, warned, ok}, 32'h1);
         if (ok !== 1'b1) finish_test();
         repeat (2) @(posedge hclk);
         check({31'h0, irq}, 32'h1);
         ahb(8'h08, 1'b0, 32'h0, rd);
         check(rd, 32'h2);
         @(posedge hclk);
         check({31'h0, irq}, 32'h0);
      end
      $display("frame test done");
      // request held on, request never raised, then steps too slow for the mode limit
      for (k = 1; k < 4; k++) begin
         ahb(8'h04, 1'b1, $random(seed), rd);
         u_ctrl.xfer((k == 3) ? 12 : 0, (k == 3) ? 0 : k, got, sum, warned, ok);
         check({30'h0, warned, ok}, 32'h3);
         if (ok !== 1'b1) finish_test();
         check({31'h0, u_ctrl.comm_error_flag}, 32'h1);
         ahb(8'h10, 1'b0, 32'h0, rd);
         check({26'h0, rd[10:9], rd[3:0]}, {26'h0, cause[k], 4'h9});
         check({30'h0, irq, rdy}, 32'h3);
         // with the clock enable low the released lines must go unseen
         ce <= 1'b0;
         u_ctrl.release_lines();
         check({31'h0, warn}, 32'h1);
         ce <= 1'b1;
         repeat (2) @(posedge hclk);
         check({31'h0, warn}, 32'h0);
         check({31'h0, u_ctrl.comm_error_flag}, 32'h0);
         ahb(8'h08, 1'b0, 32'h0, rd);
         check(rd, 32'h1);
      end
      check({31'h0, hresp}, 32'h0);
      $display("warning test done");
      finish_test();
   end
endmodule : tb
